/* File: bench/lcd_far_end.sv */
/* Far-end line model: idle ones or a repeating loop code.
   Assumes one bit every second hclk on the shared clock. */
`timescale 1ns/10ps
module lcd_far_end (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [1:0] pat,
  output logic rx_data,
  output logic rx_bit_en
);
  logic [2:0] k_reg;
  wire [2:0] last = (pat == 2'h1) ? 3'h4 : 3'h2;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {rx_bit_en, rx_data, k_reg} <= {1'b0, 1'b1, 3'h0};
    end else begin
      rx_bit_en <= ~rx_bit_en;
      if (!rx_bit_en) begin
        k_reg <= (k_reg >= last) ? 3'h0 : k_reg + 3'h1;
        rx_data <= (pat == 2'h0) | (k_reg == last);
      end else begin
        // Off-bit cycles carry junk so stale data is never trusted
        rx_data <= ~rx_data;
      end
    end
  end
endmodule

/* File: bench/lcd_loop_code_detect_properties.sv */
/* Port checker for the loop code detector.
   Assumes a bind into the detector top, with hready fed from hreadyout. */
`timescale 1ns/10ps
module lcd_loop_code_detect_props #(
  parameter longint HOLD_COUNT = 20
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic rx_data,
  input wire logic rx_bit_en,
  input wire logic remote_loopback,
  input wire logic line_code_ami,
  input wire logic irq
);
  localparam logic [31:0] HOLD = 32'(HOLD_COUNT);
  logic [4:0] hist_reg;
  logic [31:0] up_reg;
  logic [31:0] dn_reg;
  logic [2:0] wr_reg;
  logic [2:0] rd_reg;
  wire up_ok = $onehot(hist_reg);
  wire dn_ok = $onehot(hist_reg[2:0]);
  wire take = hsel & hready & htrans[1];
  // Ages saturate at 7 so an old write never excuses a change
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {hist_reg, up_reg, dn_reg, wr_reg, rd_reg} <= {5'h1f, 64'h0, 6'h3f};
    end else begin
      if (rx_bit_en) hist_reg <= {hist_reg[3:0], rx_data};
      up_reg <= up_ok ? up_reg + 32'h1 : 32'h0;
      dn_reg <= dn_ok ? dn_reg + 32'h1 : 32'h0;
      wr_reg <= (take & hwrite) ? 3'h0 : wr_reg + {2'h0, wr_reg != 3'h7};
      rd_reg <= (take & ~hwrite) ? 3'h0 : rd_reg + {2'h0, rd_reg != 3'h7};
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_lb_rise; $rose(remote_loopback) |-> $past(up_reg) >= HOLD; endproperty
  a_lb_rise: assert property (p_lb_rise) else $error("loopback rose early");
  property p_lb_live; $rose(remote_loopback) |-> $past(up_ok); endproperty
  a_lb_live: assert property (p_lb_live) else $error("loopback without code");
  property p_lb_fall; $fell(remote_loopback) |-> $past(dn_reg) >= HOLD || wr_reg < 3'h4;
  endproperty
  a_lb_fall: assert property (p_lb_fall) else $error("loopback fell");
  property p_lb_hold; remote_loopback && !dn_ok && wr_reg == 3'h7 |=> remote_loopback;
  endproperty
  a_lb_hold: assert property (p_lb_hold) else $error("loopback dropped");
  // Flag and irq register on the same edge, one cycle after the timer reaches its limit
  property p_irq_rise;
    $rose(irq) |-> $past(up_reg) >= HOLD || $past(dn_reg) >= HOLD || wr_reg < 3'h4;
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose early");
  property p_irq_fall; $fell(irq) |-> wr_reg < 3'h4; endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
  property p_code; wr_reg == 3'h7 |=> $stable(line_code_ami); endproperty
  a_code: assert property (p_code) else $error("line code moved");
  property p_rdata; $changed(hrdata) |-> rd_reg < 3'h3; endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved");
endmodule

bind lcd_loop_code_detect lcd_loop_code_detect_props #(.HOLD_COUNT(HOLD_COUNT)) u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .rx_data(rx_data), .rx_bit_en(rx_bit_en),
  .remote_loopback(remote_loopback), .line_code_ami(line_code_ami), .irq(irq));

/* File: bench/lcd_loop_code_detect_tb.sv */
/* Bench: bus tasks and loop code scenarios.
   Assumes the far-end model and the bound checker. */
`timescale 1ns/10ps
module lcd_loop_code_detect_tb;
  import lcd_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [1:0] pat = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] r;
  logic rdy, rx_data, rx_bit_en, lb, ami, irq;
  int fails = 0;
  int n_tests = 0;
  always #5 hclk = ~hclk;
  lcd_loop_code_detect #(.HOLD_COUNT(20)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(rdy),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(rdy), .hresp(), .rx_data(rx_data),
    .rx_bit_en(rx_bit_en), .remote_loopback(lb), .line_code_ami(ami), .irq(irq));
  lcd_far_end far (.hclk(hclk), .hresetn(hresetn), .pat(pat), .rx_data(rx_data),
    .rx_bit_en(rx_bit_en));
  task automatic stop_test;
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h0, a};
    do @(posedge hclk); while (rdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (rdy !== 1'b1);
    r = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(r, e);
  endtask
  // Pins update on the same edge the write lands; check them two falling edges later
  task automatic outs(input logic [2:0] e);
    repeat (2) @(negedge hclk);
    chk({29'h0, lb, ami, irq}, {29'h0, e});
  endtask
  task automatic run(input logic [1:0] p, input int n);
    pat <= p;
    repeat (n) @(posedge hclk);
  endtask
  initial begin
    // A real falling edge so the asynchronous reset is seen
    #1;
    hresetn <= 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    outs(3'b000);
    rd(ADDR_CTRL, 32'h0);
    rd(8'h40, 32'h0);
    xfer(1'b1, ADDR_CTRL, 32'h38);
    rd(ADDR_CTRL, 32'h38);
    outs(3'b010);
    xfer(1'b1, ADDR_RAIL, 32'h1);
    outs(3'b000);
    xfer(1'b1, ADDR_RAIL, 32'h0);
    xfer(1'b1, ADDR_CTRL, 32'h0);
    xfer(1'b1, ADDR_INT_MASK, 32'h3);
    run(2'h1, 80);
    rd(ADDR_INT_STAT, 32'h0);
    xfer(1'b1, ADDR_CTRL, {24'h0, MODE_DOWN, 6'h0});
    run(2'h1, 80);
    rd(ADDR_INT_STAT, 32'h0);
    xfer(1'b1, ADDR_CTRL, {24'h0, MODE_UP, 6'h0});
    // Bursts shorter than the hold time plus pipeline slack never fire
    for (int i = 0; i < 6; i++) begin
      run(2'h1, 16);
      run(2'h0, 4);
    end
    rd(ADDR_INT_STAT, 32'h0);
    run(2'h1, 80);
    rd(ADDR_INT_STAT, 32'h1);
    outs(3'b001);
    run(2'h0, 80);
    rd(ADDR_INT_STAT, 32'h1);
    xfer(1'b1, ADDR_INT_STAT, 32'h1);
    outs(3'b000);
    xfer(1'b1, ADDR_CTRL, {24'h0, MODE_DOWN, 6'h0});
    run(2'h2, 80);
    rd(ADDR_INT_STAT, 32'h1);
    xfer(1'b1, ADDR_CTRL, {24'h0, MODE_AUTO, 6'h0});
    rd(ADDR_INT_STAT, 32'h0);
    outs(3'b000);
    run(2'h1, 80);
    outs(3'b101);
    run(2'h0, 80);
    outs(3'b101);
    rd(ADDR_STATUS, 32'h5);
    run(2'h2, 80);
    outs(3'b001);
    xfer(1'b1, ADDR_INT_STAT, 32'h3);
    run(2'h1, 80);
    outs(3'b101);
    xfer(1'b1, ADDR_INT_STAT, 32'h3);
    xfer(1'b1, ADDR_CTRL, 32'h0);
    outs(3'b001);
    stop_test;
  end
  initial begin
    repeat (5000) @(posedge hclk);
    fails++;
    stop_test;
  end
endmodule

/* File: include/lcd_pkg.sv */
/*
  Package for the loop code detector: register map, field positions,
  reset values, mode codes, timing counts and the state record.
  Assumes a single 100 MHz clock and one word per register.
*/
package lcd_pkg;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RAIL = 8'h04;
  localparam logic [7:0] ADDR_INT_STAT = 8'h08;
  localparam logic [7:0] ADDR_INT_MASK = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  localparam int CTRL_MODE_LSB = 6;
  localparam int CTRL_CODE_BIT = 5;
  localparam int CTRL_SPARE_LSB = 3;
  localparam int INT_SEEN_BIT = 0;
  localparam int INT_LOOP_BIT = 1;

  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_UP = 2'h1;
  localparam logic [1:0] MODE_DOWN = 2'h2;
  localparam logic [1:0] MODE_AUTO = 2'h3;

  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic RST_CODE = 1'b0;
  localparam logic [1:0] RST_SPARE = 2'h0;
  localparam logic RST_DUAL_RAIL = 1'b0;
  localparam logic [1:0] RST_INT_MASK = 2'h0;

  localparam logic [4:0] UP_PATTERN = 5'h01;
  localparam logic [2:0] DOWN_PATTERN = 3'h1;
  localparam logic [2:0] UP_LEN = 3'h5;
  localparam logic [2:0] DOWN_LEN = 3'h3;

  localparam longint CLK_HZ = 100_000_000;
  localparam longint HOLD_TIME_S = 5;
  localparam longint HOLD_CYCLES = HOLD_TIME_S * CLK_HZ;

  typedef enum logic [1:0] {TGT_NONE, TGT_UP, TGT_DOWN} lcd_target_t;

  typedef struct packed {
    logic [1:0] mode;
    logic code_sel;
    logic [1:0] spare;
    logic dual_rail;
    logic [1:0] int_stat;
    logic [1:0] int_mask;
    logic loopback;
    lcd_target_t target;
    logic [4:0] hist;
    logic [2:0] fill;
    logic matched;
    logic fired;
    logic [31:0] timer;
    logic dp_valid;
    logic dp_write;
    logic dp_map;
    logic [7:0] dp_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic irq;
    logic line_code_ami;
  } lcd_state_t;

endpackage

/* File: logic/lcd_loop_code_detect.sv */
/*
  Receive-path network loop code detector with line-code select,
  reached over an AHB-Lite slave port.
  Assumes received bits arrive on hclk with a one-cycle bit enable,
  and that the slave is the only one on its bus segment.
*/
// Local design decisions: the AHB-Lite slave port and the register addresses.
`timescale 1ns/10ps

// What this block does
// - Mode 00 disables detection, 01 watches loop-up, 10 watches loop-down.
// - Mode 11 watches loop-up and activates remote loop-back on recognition.
// - Loop-up: repeating 00001 held over five seconds sets the seen flag.
// - Loop-down: repeating 001 held over five seconds sets the seen flag.
// - Seen flag set with its enable high raises the interrupt.
// - Entering automatic mode clears the seen flag and watches for loop-up.
// - Automatic mode: loop-up over five seconds sets flag and enables loop-back.
// - After loop-back starts, automatic mode switches to watching loop-down.
// - Seen flag stays set when the loop-up pattern stops.
// - Loop-back ends only on loop-down or on leaving automatic mode.
// - Line-code select 0 picks HDB3, 1 picks AMI.
// - Line-code select acts only in single-rail operation.
// - Control bits 4-3 are spare, read/write, reset to 00.
module lcd_loop_code_detect #(
  parameter longint HOLD_COUNT = lcd_pkg::HOLD_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rx_data,
  input wire logic rx_bit_en,
  output logic remote_loopback,
  output logic line_code_ami,
  output logic irq
);
  import lcd_pkg::*;

  localparam logic [31:0] HOLD_LAST = 32'(HOLD_COUNT);

  lcd_state_t s_reg;
  lcd_state_t s_next;

  // Exactly one 1 in every window means the stream repeats the pattern
  function automatic logic window_ok(input logic [4:0] h, input lcd_target_t t);
    logic ok;
    ok = 1'b0;
    case (t)
      TGT_UP: begin
        ok = ($countones(h) == 1);
      end
      TGT_DOWN: begin
        ok = ($countones(h[2:0]) == 1);
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    return ok;
  endfunction

  function automatic logic [2:0] window_len(input lcd_target_t t);
    return (t == TGT_UP) ? UP_LEN : DOWN_LEN;
  endfunction

  always_comb begin
    logic [1:0] clr;
    logic [1:0] set;
    logic [4:0] hist_new;
    s_next = s_reg;
    clr = 2'h0;
    set = 2'h0;
    hist_new = 5'h00;
    s_next.hreadyout = 1'b1;
    s_next.hresp = 1'b0;

    // Data phase of a write
    if (s_reg.dp_valid && s_reg.dp_write && s_reg.dp_map) begin
      if (s_reg.dp_addr == ADDR_CTRL) begin
        s_next.mode = hwdata[CTRL_MODE_LSB +: 2];
        s_next.code_sel = hwdata[CTRL_CODE_BIT];
        s_next.spare = hwdata[CTRL_SPARE_LSB +: 2];
      end else if (s_reg.dp_addr == ADDR_RAIL) begin
        s_next.dual_rail = hwdata[0];
      end else if (s_reg.dp_addr == ADDR_INT_STAT) begin
        clr = hwdata[1:0];
      end else if (s_reg.dp_addr == ADDR_INT_MASK) begin
        s_next.int_mask = hwdata[1:0];
      end
    end

    if (s_next.mode == MODE_AUTO && s_reg.mode != MODE_AUTO) begin
      clr[INT_SEEN_BIT] = 1'b1;
    end
    if (s_next.mode != MODE_AUTO && s_reg.loopback) begin
      s_next.loopback = 1'b0;
      set[INT_LOOP_BIT] = 1'b1;
    end

    case (s_next.mode)
      MODE_UP: begin
        s_next.target = TGT_UP;
      end
      MODE_DOWN: begin
        s_next.target = TGT_DOWN;
      end
      MODE_AUTO: begin
        s_next.target = s_reg.loopback ? TGT_DOWN : TGT_UP;
      end
      default: begin
        s_next.target = TGT_NONE;
      end
    endcase

    // Bit history and pattern match
    if (s_next.target != s_reg.target) begin
      s_next.fill = 3'h0;
      s_next.matched = 1'b0;
      s_next.hist = 5'h00;
    end else if (rx_bit_en) begin
      hist_new = {s_reg.hist[3:0], rx_data};
      s_next.hist = hist_new;
      if (s_reg.fill != UP_LEN) begin
        s_next.fill = s_reg.fill + 3'h1;
      end
      s_next.matched = (s_next.fill >= window_len(s_reg.target))
                       && window_ok(hist_new, s_reg.target);
    end

    // Persistence timer; a broken pattern starts over
    if (!s_reg.matched || s_next.target != s_reg.target) begin
      s_next.timer = 32'h0;
      s_next.fired = 1'b0;
    end else if (s_reg.timer != HOLD_LAST) begin
      s_next.timer = s_reg.timer + 32'h1;
    end else if (!s_reg.fired) begin
      // Timer at the limit with the pattern still present: over the hold time
      s_next.fired = 1'b1;
      set[INT_SEEN_BIT] = 1'b1;
      if (s_reg.mode == MODE_AUTO && s_reg.target == TGT_UP) begin
        s_next.loopback = 1'b1;
        set[INT_LOOP_BIT] = 1'b1;
      end else if (s_reg.mode == MODE_AUTO && s_reg.target == TGT_DOWN) begin
        s_next.loopback = 1'b0;
        set[INT_LOOP_BIT] = 1'b1;
      end
    end

    // Set wins over a same-cycle clear; only software clears the flag
    s_next.int_stat = (s_reg.int_stat & ~clr) | set;
    s_next.irq = |(s_next.int_stat & s_next.int_mask);
    s_next.line_code_ami = s_next.code_sel & ~s_next.dual_rail;

    // Address phase; read data is built from the updated state
    if (hsel && hready && htrans[1]) begin
      s_next.dp_valid = 1'b1;
      s_next.dp_write = hwrite;
      s_next.dp_addr = haddr[7:0];
      s_next.dp_map = (haddr[31:8] == 24'h0);
      if (!hwrite) begin
        s_next.hrdata = 32'h0;
        if (haddr[31:8] != 24'h0) begin
          s_next.hrdata = 32'h0;
        end else if (haddr[7:0] == ADDR_CTRL) begin
          s_next.hrdata[CTRL_MODE_LSB +: 2] = s_next.mode;
          s_next.hrdata[CTRL_CODE_BIT] = s_next.code_sel;
          s_next.hrdata[CTRL_SPARE_LSB +: 2] = s_next.spare;
        end else if (haddr[7:0] == ADDR_RAIL) begin
          s_next.hrdata[0] = s_next.dual_rail;
        end else if (haddr[7:0] == ADDR_INT_STAT) begin
          s_next.hrdata[1:0] = s_next.int_stat;
        end else if (haddr[7:0] == ADDR_INT_MASK) begin
          s_next.hrdata[1:0] = s_next.int_mask;
        end else if (haddr[7:0] == ADDR_STATUS) begin
          s_next.hrdata[0] = s_next.loopback;
          s_next.hrdata[2:1] = s_next.target;
          s_next.hrdata[3] = s_next.matched;
        end
      end
    end else begin
      s_next.dp_valid = 1'b0;
      s_next.dp_write = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '{mode: RST_MODE, code_sel: RST_CODE, spare: RST_SPARE,
                 dual_rail: RST_DUAL_RAIL, int_stat: 2'h0, int_mask: RST_INT_MASK,
                 loopback: 1'b0, target: TGT_NONE, hist: 5'h00, fill: 3'h0,
                 matched: 1'b0, fired: 1'b0, timer: 32'h0, dp_valid: 1'b0,
                 dp_write: 1'b0, dp_map: 1'b0, dp_addr: 8'h00, hrdata: 32'h0,
                 hreadyout: 1'b1, hresp: 1'b0, irq: 1'b0, line_code_ami: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign hrdata = s_reg.hrdata;
  assign hreadyout = s_reg.hreadyout;
  assign hresp = s_reg.hresp;
  assign remote_loopback = s_reg.loopback;
  assign line_code_ami = s_reg.line_code_ami;
  assign irq = s_reg.irq;

endmodule
